// >>> core/stach_consts.svh
// Offsets, command codes, field values and timing counts of the handler
`ifndef STACH_CONSTS_SVH
`define STACH_CONSTS_SVH

// APB register byte offsets
`define STACH_OFS_CMD      12'h000
`define STACH_OFS_DATA     12'h004
`define STACH_OFS_RESP     12'h008
`define STACH_OFS_STAT     12'h00C
`define STACH_OFS_FORCED   12'h010

// Positioning test step control
`define STACH_CMD_STEP     8'hA0
`define STACH_DNO_STEP     8'h41
`define STACH_CODE_STOP    32'h5354_4F50
`define STACH_CODE_RESTART 32'h0047_3020
`define STACH_CODE_RDCLR   32'h434C_5220

// Test operation mode select
`define STACH_CMD_TMODE    8'h8B
`define STACH_DNO_TMODE    8'h00
`define STACH_TSEL_OFF     16'h0000
`define STACH_TSEL_JOG     16'h0001
`define STACH_TSEL_POS     16'h0002
`define STACH_TSEL_FORCE   16'h0004
`define STACH_TM_OFF       3'h0
`define STACH_TM_JOG       3'h1
`define STACH_TM_POS       3'h2
`define STACH_TM_FORCE     3'h4

// Forced output word
`define STACH_CMD_OUTSET   8'h92
`define STACH_DNO_OUTSET   8'hA0
`define STACH_OUT_BITS     9

// Alarm history and clears
`define STACH_CMD_HIST     8'h33
`define STACH_HIST_CODE    4'h1
`define STACH_HIST_HOURS   4'h2
`define STACH_HIST_DETAIL  4'h4
`define STACH_HIST_N       16
`define STACH_CMD_CLR      8'h82
`define STACH_DNO_HCLR     8'h20
`define STACH_DNO_ARST     8'h00
`define STACH_KEY          16'h1EA5
`define STACH_NO_ALARM     16'h00FF

// Monitor reads
`define STACH_CMD_MON      8'h02
`define STACH_DNO_CUR      8'h00
`define STACH_DNO_CURDET   8'h03
`define STACH_DNO_VER      8'h70
`define STACH_DNO_ABSPUL   8'h90
`define STACH_DNO_ABSCMD   8'h91

// Status snapshot at alarm
`define STACH_CMD_SNAP     8'h35
`define STACH_SNAP_A_HI    4'h8
`define STACH_SNAP_A_MAX   4'hE
`define STACH_SNAP_B_HI    4'hA
`define STACH_SNAP_B_MAX   4'h9
`define STACH_SNAP_N       25
`define STACH_SNAP_B_BASE  5'd15
`define STACH_PROC_INFO    8'h00

// Timing
`define STACH_CLK_HZ       100000000
`define STACH_TIMEOUT_MS   500
`define STACH_HOUR_S       3600

`endif

// >>> core/stach_pkg.sv
// Types shared by the servo test and alarm command handler
package stach_pkg;

  typedef struct packed {
    logic [15:0] code;
    logic [15:0] detail;
    logic [15:0] hours;
  } stach_alm_entry_t;

  typedef struct packed {
    logic        active;
    logic [15:0] code;
    logic [15:0] detail;
  } stach_alarm_t;

  typedef struct packed {
    logic [31:0] pulse;
    logic [31:0] cmd;
  } stach_abs_pos_t;

  typedef enum logic [2:0] {
    STACH_IDLE = 3'b001,
    STACH_RUN  = 3'b010,
    STACH_HALT = 3'b100
  } stach_motion_t;

  typedef struct packed {
    stach_alm_entry_t [15:0] ent;
  } stach_hist_state_t;

  typedef struct packed {
    logic [2:0]        test_mode;
    stach_motion_t     motion;
    logic [8:0]        forced;
    logic [31:0]       data;
    logic [31:0]       resp;
    logic [7:0]        aux;
    logic              cmd_err;
    logic              resume;
    logic              rdclr;
    logic              arst;
    logic              servo_lock;
    logic [39:0]       hour_cnt;
    logic [15:0]       hours;
    logic [31:0]       to_cnt;
    logic [24:0][31:0] snap;
  } stach_state_t;

endpackage : stach_pkg

// >>> core/stach_alm_hist.sv
// Sixteen-entry alarm history, newest at entry zero
`timescale 1ns/1ps
`include "stach_consts.svh"
module stach_alm_hist (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      push,
  input  wire logic                      clear,
  input  wire stach_pkg::stach_alm_entry_t entry_in,
  input  wire logic [3:0]                idx,
  output stach_pkg::stach_alm_entry_t    rd,
  output logic [15:0]                    newest_code
);

  localparam stach_pkg::stach_alm_entry_t EMPTY =
    '{code: `STACH_NO_ALARM, detail: 16'h0000, hours: 16'h0000};

  stach_pkg::stach_hist_state_t s;
  stach_pkg::stach_hist_state_t next_s;

  // Clear first, then push, so an alarm in the clear cycle survives
  always_comb begin
    next_s = s;
    if (clear) begin
      for (int i = 0; i < `STACH_HIST_N; i++) begin
        next_s.ent[i] = EMPTY;
      end
    end
    if (push) begin
      for (int i = `STACH_HIST_N - 1; i > 0; i--) begin
        next_s.ent[i] = clear ? EMPTY : s.ent[i-1];
      end
      next_s.ent[0] = entry_in;
    end
  end

  // Reset shows an empty history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `STACH_HIST_N; i++) begin
        s.ent[i] <= '{code: `STACH_NO_ALARM, detail: 16'h0000,
                      hours: 16'h0000};
      end
    end else begin
      s <= next_s;
    end
  end

  // Read port indexed by the low digit of the data number
  assign rd          = s.ent[idx];
  assign newest_code = s.ent[0].code;

endmodule : stach_alm_hist

// >>> core/stach_top.sv
// Servo test operation and alarm command handler with APB registers
// Overview of operation
// - STOP on step control during positioning run decelerates and holds.
// - Restart code during temporary stop resumes interrupted positioning.
// - Clear code during temporary stop ends positioning, drops remainder.
// - Mode select 0004 enters forced output; pins follow commands only.
// - Output word bits 0 to 8 drive pins; higher bits unused.
// - Mode select 0000 ends forced output and cancels test mode.
// - Sixteen-entry history, newest zero; data numbers 10-1F read codes.
// - Alarm numbers are four hex digits; 00FF means no alarm.
// - Data numbers 40-4F return the alarm detail number per entry.
// - Data numbers 20-2F return occurrence hours since start.
// - Command 82 number 20 with key 1EA5 erases the history.
// - Command 02 number 00 returns the active alarm number.
// - Number 03 returns alarm and detail; 00FF0000 means none.
// - Command 35 returns snapshot captured at alarm, with processing info.
// - Command 82 number 00 with key resets alarm like reset input.
// - Command 02 number 70 returns the firmware version string.
// - Number 90 returns absolute position in motor pulses, 32 bits.
// - Number 91 returns absolute position in command units.
// - Silence of 0.5 s in test mode stops motor and servo-locks.
//
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "stach_consts.svh"
module stach_top #(
  parameter logic [31:0] TIMEOUT_CYCLES =
    32'(`STACH_TIMEOUT_MS * (`STACH_CLK_HZ / 1000)),
  parameter logic [39:0] HOUR_CYCLES =
    40'(64'(`STACH_HOUR_S) * 64'(`STACH_CLK_HZ)),
  // Arbitrary neutral version characters
  parameter logic [31:0] FW_VERSION = 32'h5630_3031
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [11:0]             paddr,
  input  wire logic [31:0]             pwdata,
  output logic [31:0]                  prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic                    pos_running,
  input  wire logic                    alarm_event,
  input  wire stach_pkg::stach_alarm_t alarm_cur,
  input  wire stach_pkg::stach_abs_pos_t abs_pos,
  input  wire logic [24:0][31:0]       status_live,
  output logic                         motion_halt,
  output logic                         motion_resume,
  output logic                         remaining_clear,
  output logic                         servo_lock,
  output logic [2:0]                   test_mode,
  output logic                         forced_out_en,
  output logic [8:0]                   forced_out,
  output logic                         alarm_reset_input
);

  stach_pkg::stach_state_t     s;
  stach_pkg::stach_state_t     next_s;
  stach_pkg::stach_alm_entry_t hist_rd;
  logic [15:0]                 hist_newest;
  logic                        acc;
  logic                        exec;
  logic                        mapped;
  logic [7:0]                  cmd;
  logic [7:0]                  dno;
  logic                        is_step;
  logic                        is_stop;
  logic                        is_restart;
  logic                        is_rdclr;
  logic                        is_tmode;
  logic                        hist_clear;
  logic                        to_fire;
  logic [4:0]                  snap_idx;
  logic                        snap_ok;

  // Command issue is a completed write of the command word
  assign acc  = psel && penable;
  assign exec = acc && pwrite && (paddr == `STACH_OFS_CMD);
  assign cmd  = pwdata[15:8];
  assign dno  = pwdata[7:0];

  // Step-control decode of the buffered data word
  assign is_step    = exec && cmd == `STACH_CMD_STEP &&
                      dno == `STACH_DNO_STEP;
  assign is_stop    = is_step && s.data == `STACH_CODE_STOP;
  assign is_restart = is_step && s.data == `STACH_CODE_RESTART;
  assign is_rdclr   = is_step && s.data == `STACH_CODE_RDCLR;
  assign is_tmode   = exec && cmd == `STACH_CMD_TMODE &&
                      dno == `STACH_DNO_TMODE;
  assign hist_clear = exec && cmd == `STACH_CMD_CLR &&
                      dno == `STACH_DNO_HCLR && s.data[15:0] == `STACH_KEY;

  // Silence watchdog fires only in test mode and never on an issue cycle
  assign to_fire = (s.test_mode != `STACH_TM_OFF) && !exec &&
                   (s.to_cnt == TIMEOUT_CYCLES - 32'd1);

  // Snapshot item index: 80-8E map to 0-14, A0-A9 to 15-24
  always_comb begin
    snap_idx = 5'd0;
    snap_ok  = 1'b0;
    if (dno[7:4] == `STACH_SNAP_A_HI && dno[3:0] <= `STACH_SNAP_A_MAX) begin
      snap_idx = {1'b0, dno[3:0]};
      snap_ok  = 1'b1;
    end else if (dno[7:4] == `STACH_SNAP_B_HI &&
                 dno[3:0] <= `STACH_SNAP_B_MAX) begin
      snap_idx = `STACH_SNAP_B_BASE + {1'b0, dno[3:0]};
      snap_ok  = 1'b1;
    end
  end

  stach_alm_hist u_hist (
    .pclk        (pclk),
    .presetn     (presetn),
    .push        (alarm_event),
    .clear       (hist_clear),
    .entry_in    ('{code: alarm_cur.code, detail: alarm_cur.detail,
                    hours: s.hours}),
    .idx         (dno[3:0]),
    .rd          (hist_rd),
    .newest_code (hist_newest)
  );

  // Whole next state; one issue per write, answers land in the response
  always_comb begin
    next_s         = s;
    next_s.resume  = 1'b0;
    next_s.rdclr   = 1'b0;
    next_s.arst    = 1'b0;
    // Hour counter gives occurrence time with minutes dropped
    if (s.hour_cnt == HOUR_CYCLES - 40'd1) begin
      next_s.hour_cnt = 40'd0;
      next_s.hours    = s.hours + 16'd1;
    end else begin
      next_s.hour_cnt = s.hour_cnt + 40'd1;
    end
    // Any issued command counts as live communication
    if (exec || s.test_mode == `STACH_TM_OFF) begin
      next_s.to_cnt = 32'd0;
    end else if (!to_fire) begin
      next_s.to_cnt = s.to_cnt + 32'd1;
    end
    if (to_fire) begin
      next_s.servo_lock = 1'b1;
      next_s.motion     = stach_pkg::STACH_IDLE;
    end
    // Positioning begins outside this block; track it only when idle
    // A watchdog trip outranks a starting run, so the lock holds still
    if (!exec && !s.servo_lock && s.motion == stach_pkg::STACH_IDLE &&
        s.test_mode == `STACH_TM_POS && pos_running && !to_fire) begin
      next_s.motion = stach_pkg::STACH_RUN;
    end else if (!exec && s.motion == stach_pkg::STACH_RUN && !pos_running)
    begin
      next_s.motion = stach_pkg::STACH_IDLE;
    end
    // Capture live status at the alarm edge
    if (alarm_event) begin
      next_s.snap = status_live;
    end
    if (acc && pwrite && paddr == `STACH_OFS_DATA) begin
      next_s.data = pwdata;
    end
    if (exec) begin
      next_s.cmd_err = 1'b0;
      next_s.resp    = 32'h0000_0000;
      next_s.aux     = 8'h00;
      case (cmd)
        `STACH_CMD_STEP: begin
          // Unknown codes and codes in the wrong state leave motion as is
          if (dno != `STACH_DNO_STEP) begin
            next_s.cmd_err = 1'b1;
          end else if (is_stop && s.motion == stach_pkg::STACH_RUN) begin
            next_s.motion = stach_pkg::STACH_HALT;
          end else if (is_restart && s.motion == stach_pkg::STACH_HALT) begin
            next_s.motion = stach_pkg::STACH_RUN;
            next_s.resume = 1'b1;
          end else if (is_rdclr && s.motion == stach_pkg::STACH_HALT) begin
            next_s.motion = stach_pkg::STACH_IDLE;
            next_s.rdclr  = 1'b1;
          end else begin
            next_s.cmd_err = 1'b1;
          end
        end
        `STACH_CMD_TMODE: begin
          next_s.servo_lock = 1'b0;
          next_s.motion     = stach_pkg::STACH_IDLE;
          next_s.forced     = 9'h000;
          if (!is_tmode) begin
            next_s.cmd_err    = 1'b1;
            next_s.servo_lock = s.servo_lock;
            next_s.motion     = s.motion;
            next_s.forced     = s.forced;
          end else if (s.data[15:0] == `STACH_TSEL_OFF) begin
            next_s.test_mode = `STACH_TM_OFF;
          end else if (s.data[15:0] == `STACH_TSEL_JOG) begin
            next_s.test_mode = `STACH_TM_JOG;
          end else if (s.data[15:0] == `STACH_TSEL_POS) begin
            next_s.test_mode = `STACH_TM_POS;
          end else if (s.data[15:0] == `STACH_TSEL_FORCE) begin
            next_s.test_mode = `STACH_TM_FORCE;
          end else begin
            next_s.cmd_err    = 1'b1;
            next_s.servo_lock = s.servo_lock;
            next_s.motion     = s.motion;
            next_s.forced     = s.forced;
          end
        end
        `STACH_CMD_OUTSET: begin
          // Bits above 8 have no pin and are dropped
          if (dno == `STACH_DNO_OUTSET && s.test_mode == `STACH_TM_FORCE)
          begin
            next_s.forced = s.data[`STACH_OUT_BITS-1:0];
          end else begin
            next_s.cmd_err = 1'b1;
          end
        end
        `STACH_CMD_HIST: begin
          if (dno[7:4] == `STACH_HIST_CODE) begin
            next_s.resp = {16'h0000, hist_rd.code};
          end else if (dno[7:4] == `STACH_HIST_DETAIL) begin
            next_s.resp = {16'h0000, hist_rd.detail};
          end else if (dno[7:4] == `STACH_HIST_HOURS) begin
            next_s.resp = {16'h0000, hist_rd.hours};
          end else begin
            next_s.cmd_err = 1'b1;
          end
        end
        `STACH_CMD_CLR: begin
          if (s.data[15:0] != `STACH_KEY) begin
            next_s.cmd_err = 1'b1;
          end else if (dno == `STACH_DNO_ARST) begin
            next_s.arst = 1'b1;
          end else if (dno != `STACH_DNO_HCLR) begin
            next_s.cmd_err = 1'b1;
          end
        end
        `STACH_CMD_MON: begin
          case (dno)
            `STACH_DNO_CUR: begin
              next_s.resp = {16'h0000, alarm_cur.active ?
                             alarm_cur.code : `STACH_NO_ALARM};
            end
            `STACH_DNO_CURDET: begin
              next_s.resp = alarm_cur.active ?
                {alarm_cur.code, alarm_cur.detail} :
                {`STACH_NO_ALARM, 16'h0000};
            end
            `STACH_DNO_VER:    next_s.resp = FW_VERSION;
            `STACH_DNO_ABSPUL: next_s.resp = abs_pos.pulse;
            `STACH_DNO_ABSCMD: next_s.resp = abs_pos.cmd;
            default:           next_s.cmd_err = 1'b1;
          endcase
        end
        `STACH_CMD_SNAP: begin
          if (snap_ok) begin
            next_s.resp = s.snap[snap_idx];
            next_s.aux  = `STACH_PROC_INFO;
          end else begin
            next_s.cmd_err = 1'b1;
          end
        end
        default: next_s.cmd_err = 1'b1;
      endcase
    end
  end

  // Single state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '{test_mode: `STACH_TM_OFF, motion: stach_pkg::STACH_IDLE,
             default: '0};
    end else begin
      s <= next_s;
    end
  end

  // Zero-wait slave; unmapped offsets answer with an error
  always_comb begin
    mapped = 1'b1;
    prdata = 32'h0000_0000;
    case (paddr)
      `STACH_OFS_CMD:    prdata = 32'h0000_0000;
      `STACH_OFS_DATA:   prdata = s.data;
      `STACH_OFS_RESP:   prdata = s.resp;
      `STACH_OFS_STAT:   prdata = {8'h00, s.aux, 7'h00, s.cmd_err,
                                   s.servo_lock, s.motion, 1'b0,
                                   s.test_mode};
      `STACH_OFS_FORCED: prdata = {23'h00_0000, s.forced};
      default:           mapped = 1'b0;
    endcase
  end

  assign pready  = 1'b1;
  assign pslverr = acc && !mapped;

  // Forced pins act only in forced output mode, regardless of servo state
  assign forced_out_en     = (s.test_mode == `STACH_TM_FORCE);
  assign forced_out        = s.forced;
  assign motion_halt       = (s.motion == stach_pkg::STACH_HALT) ||
                             s.servo_lock;
  assign motion_resume     = s.resume;
  assign remaining_clear   = s.rdclr;
  assign servo_lock        = s.servo_lock;
  assign test_mode         = s.test_mode;
  assign alarm_reset_input = s.arst;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_stop;
    is_stop && s.motion == stach_pkg::STACH_RUN |=>
      s.motion == stach_pkg::STACH_HALT && motion_halt;
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop did not halt motion");

  property p_restart;
    is_restart && s.motion == stach_pkg::STACH_HALT |=>
      motion_resume && s.motion == stach_pkg::STACH_RUN ##1 !motion_resume;
  endproperty
  a_restart: assert property (p_restart)
    else $error("restart did not resume motion");

  property p_rdclr;
    is_rdclr && s.motion == stach_pkg::STACH_HALT |=>
      remaining_clear && !motion_halt && s.motion == stach_pkg::STACH_IDLE;
  endproperty
  a_rdclr: assert property (p_rdclr)
    else $error("clear did not end positioning");

  property p_ignore;
    (is_stop || is_restart || is_rdclr) &&
      s.motion == stach_pkg::STACH_IDLE |=>
      s.motion == stach_pkg::STACH_IDLE && !motion_resume && s.cmd_err;
  endproperty
  a_ignore: assert property (p_ignore)
    else $error("step command outside its state changed motion");

  property p_outset;
    exec && cmd == `STACH_CMD_OUTSET && dno == `STACH_DNO_OUTSET &&
      forced_out_en |=> forced_out == $past(s.data[8:0]) && forced_out_en;
  endproperty
  a_outset: assert property (p_outset)
    else $error("forced pins do not follow output word");

  property p_cancel;
    is_tmode && s.data[15:0] == `STACH_TSEL_OFF |=>
      test_mode == `STACH_TM_OFF && !forced_out_en && forced_out == 9'h000;
  endproperty
  a_cancel: assert property (p_cancel)
    else $error("mode cancel left forced output active");

  property p_hclear;
    hist_clear && !alarm_event |=> hist_newest == `STACH_NO_ALARM;
  endproperty
  a_hclear: assert property (p_hclear)
    else $error("history clear left an entry");

  property p_arst;
    exec && cmd == `STACH_CMD_CLR && dno == `STACH_DNO_ARST &&
      s.data[15:0] == `STACH_KEY |=> alarm_reset_input ##1 !alarm_reset_input;
  endproperty
  a_arst: assert property (p_arst)
    else $error("alarm reset pulse missing");

  property p_cur;
    exec && cmd == `STACH_CMD_MON && dno == `STACH_DNO_CURDET &&
      !alarm_cur.active |=> s.resp == 32'h00FF_0000;
  endproperty
  a_cur: assert property (p_cur)
    else $error("no-alarm answer wrong");

  property p_timeout;
    to_fire |=> servo_lock && motion_halt && !motion_resume;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("silence did not servo-lock");

  c_stop_restart: cover property (is_stop ##[1:20] is_restart);
  c_rdclr: cover property (remaining_clear);
  c_timeout: cover property (to_fire);
  c_forced: cover property (forced_out_en && forced_out != 9'h000);

endmodule : stach_top

// >>> tb/stach_host.sv
// Master station model: APB transfers and command issue
`timescale 1ns/1ps
`include "stach_consts.svh"
module stach_host (
  input  wire logic        pclk,
  input  wire logic        pready,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata
);
  // Bus idle from time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end

  // One transfer, entered just after a rising edge; one idle edge after
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) testbench.hang();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer

  // Data word first, then the issuing write; only the issuing write keeps the link alive
  task automatic cmd(input logic [7:0] c, dn, input logic [31:0] d);
    xfer(1'b1, `STACH_OFS_DATA, d);
    xfer(1'b1, `STACH_OFS_CMD, {16'h0000, c, dn});
  endtask : cmd

  // Command 90 with key 1EA5, which the handler rejects, sent before forced output is selected
  task automatic force_mode();
    cmd(8'h90, 8'h00, 32'h0000_1EA5);
    cmd(8'h8B, 8'h00, 32'h0000_0004);
  endtask : force_mode
endmodule : stach_host

// >>> tb/testbench.sv
// Self-checking bench for the servo test and alarm command handler
`timescale 1ns/1ps
`include "stach_consts.svh"
module testbench;
  logic pclk = 1'b0, presetn = 1'b0, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rnd = 32'h0000_15ed, s, w;
  logic pos_running = 1'b0, alarm_event = 1'b0, halt, lock, fen;
  stach_pkg::stach_alarm_t alarm_cur = '0;
  stach_pkg::stach_abs_pos_t abs_pos = '0;
  logic [24:0][31:0] status_live = '0;
  logic res_p, clr_p, arst_p;
  logic [2:0] tmode;
  logic [8:0] fout;
  logic [15:0] code [3], det [3], hrs [3];
  logic [32:0] exq [$];
  int error_cnt = 0, n_checks = 0, n_res = 0, n_clr = 0, n_arst = 0;
  int cyc = 0;

  stach_top #(.TIMEOUT_CYCLES(32'd50), .HOUR_CYCLES(40'h00_0000_0014)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pos_running(pos_running),
    .alarm_event(alarm_event), .alarm_cur(alarm_cur), .abs_pos(abs_pos),
    .status_live(status_live), .motion_halt(halt), .motion_resume(res_p),
    .remaining_clear(clr_p), .servo_lock(lock), .test_mode(tmode),
    .forced_out_en(fen), .forced_out(fout), .alarm_reset_input(arst_p));
  stach_host i_host (.pclk(pclk), .pready(pready), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

  // 100 MHz clock
  always #5 pclk = ~pclk;

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr

  task automatic chk(input string nm, input logic [32:0] sn, e);
    n_checks++;
    if (sn !== e) begin
      error_cnt++;
      $display("MISMATCH %s exp %h seen %h", nm, e, sn);
    end
  endtask : chk

  task automatic results();
    $display("errors %0d checks %0d", error_cnt, n_checks);
    if (error_cnt == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results

  task automatic hang();
    error_cnt++;
    results();
  endtask : hang

  // Note expected read, then run the read
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    exq.push_back(e);
    i_host.xfer(1'b0, a, 32'h0000_0000);
  endtask : rd

  task automatic q(input logic [7:0] c, dn, input logic [31:0] d, e);
    i_host.cmd(c, dn, d);
    rd(`STACH_OFS_RESP, {1'b0, e});
  endtask : q

  // Pulses and elapsed cycles counted on the falling edge, clear of races
  always @(negedge pclk) begin
    n_res += res_p;
    n_clr += clr_p;
    n_arst += arst_p;
    if (presetn) cyc++;
  end

  // Read results against oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite)
      chk("read", {pslverr, prdata}, exq.pop_front());
  end

  // Main sequence
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`STACH_OFS_STAT, 33'h0_0000_0010);
    rd(12'h0FC, 33'h1_0000_0000);
    pos_running <= 1'b1;
    q(8'h8B, 8'h00, 32'h0000_0002, 32'h0);
    rd(`STACH_OFS_STAT, 33'h0_0000_0022);
    i_host.cmd(8'hA0, 8'h41, `STACH_CODE_RESTART);
    rd(`STACH_OFS_STAT, 33'h0_0000_0122);
    i_host.cmd(8'hA0, 8'h41, `STACH_CODE_STOP);
    rd(`STACH_OFS_STAT, 33'h0_0000_0042);
    chk("halt", halt, 1);
    i_host.cmd(8'hA0, 8'h41, `STACH_CODE_RESTART);
    chk("resume", n_res, 1);
    i_host.cmd(8'hA0, 8'h41, `STACH_CODE_STOP);
    i_host.cmd(8'hA0, 8'h41, `STACH_CODE_RDCLR);
    chk("rdclr", {n_clr[0], halt}, 2'b10);
    repeat (80) @(posedge pclk);
    chk("lock", {lock, halt}, 2'b11);
    i_host.cmd(8'hA0, 8'h41, `STACH_CODE_STOP);
    rd(`STACH_OFS_STAT, 33'h0_0000_0192);
    i_host.cmd(8'h8B, 8'h00, 32'h0000_0000);
    chk("mode", {lock, tmode}, 4'h0);
    pos_running <= 1'b0;
    rnd = lfsr(rnd);
    w = rnd;
    i_host.force_mode();
    i_host.cmd(8'h92, 8'hA0, w);
    chk("pins", {fen, fout}, {1'b1, w[8:0]});
    rd(`STACH_OFS_FORCED, {24'h0, w[8:0]});
    i_host.cmd(8'h8B, 8'h00, 32'h0000_0000);
    chk("unforce", {fen, fout, tmode}, 13'h0);
    s = rnd;
    for (int i = 0; i < 25; i++) status_live[i] <= s ^ 32'(i);
    for (int k = 0; k < 3; k++) begin
      rnd = lfsr(rnd);
      code[k] = rnd[15:0];
      det[k] = rnd[31:16];
      alarm_cur <= '{1'b1, rnd[15:0], rnd[31:16]};
      alarm_event <= 1'b1;
      hrs[k] = 16'(cyc / 20);
      @(posedge pclk);
      alarm_event <= 1'b0;
      @(posedge pclk);
    end
    status_live <= '0;
    for (int i = 0; i < 4; i++) begin
      q(8'h33, 8'h10 + 8'(i), 0, i < 3 ? code[2-i] : 16'h00FF);
      q(8'h33, 8'h40 + 8'(i), 0, i < 3 ? det[2-i] : 16'h0);
      q(8'h33, 8'h20 + 8'(i), 0, i < 3 ? hrs[2-i] : 16'h0);
    end
    q(8'h02, 8'h00, 0, {16'h0, code[2]});
    q(8'h02, 8'h03, 0, {code[2], det[2]});
    q(8'h35, 8'h80, 0, s);
    q(8'h35, 8'hA9, 0, s ^ 32'd24);
    i_host.cmd(8'h82, 8'h00, 32'h0000_1EA4);
    i_host.cmd(8'h82, 8'h00, 32'h0000_1EA5);
    chk("arst", n_arst, 1);
    alarm_cur <= '0;
    q(8'h02, 8'h03, 0, 32'h00FF_0000);
    q(8'h02, 8'h00, 0, 32'h0000_00FF);
    i_host.cmd(8'h82, 8'h20, 32'h0000_1EA5);
    q(8'h33, 8'h10, 0, 32'h0000_00FF);
    q(8'h02, 8'h70, 0, 32'h5630_3031);
    abs_pos <= {lfsr(rnd), rnd};
    q(8'h02, 8'h90, 0, lfsr(rnd));
    q(8'h02, 8'h91, 0, rnd);
    results();
  end
endmodule : testbench
